//--- design/harvest_energy_monitor.sv
// energy monitor with axi4-lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// - two modes: count converter pulses or integrate transferred energy
// - host sets window length; energy derived from pulses inside window
// - pulse mode counts every converter pulse in the window as result
// - power mode accumulates moved energy across the window as result
// - after the window, idle for a wait phase equal to the window
// - cycle end raises interrupt pin only if done enable is one
// - cycle end sets done flag and publishes result; host reads it
// - after reset only bus-ready interrupt enabled; others until host writes
module harvest_energy_monitor #(
   parameter int TICK_CYC = hem_pkg::TICK_CYC,
   parameter int WIN_W    = hem_pkg::WIN_W,
   parameter int ENERGY_W = hem_pkg::ENERGY_W,
   parameter int RESULT_W = hem_pkg::RESULT_W
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                conv_pulse_i,
   input  wire logic [ENERGY_W-1:0] pulse_energy_i,
   output logic                     irq_o,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);

   typedef struct packed {
      logic                 awready;
      logic                 wready;
      logic                 aw_have;
      logic                 w_have;
      logic [7:0]           waddr;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic                 enable;
      logic                 mode;
      logic [WIN_W-1:0]     window;
      logic [1:0]           irq_en;
      logic [1:0]           flags;
      logic [RESULT_W-1:0]  result;
      hem_pkg::phase_t      phase;
      logic [WIN_W-1:0]     win_cnt;
      logic                 booted;
      logic                 irq;
   } mon_state_t;

   mon_state_t          state_ff;
   mon_state_t          nxt_state;
   logic                tick;
   logic                acc_clr;
   logic                acc_pulse;
   logic [RESULT_W-1:0] acc_sum;
   logic                publish;
   logic                phase_end;
   logic [1:0]          flag_set;
   logic [1:0]          flag_clr;
   logic [WIN_W-1:0]    win_len;

   // ****************************************
   // register read decode
   // ****************************************
   function automatic logic [31:0] read_reg(input mon_state_t s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         hem_pkg::OFF_CTRL: begin
            r[hem_pkg::CTRL_EN_BIT]   = s.enable;
            r[hem_pkg::CTRL_MODE_BIT] = s.mode;
         end
         hem_pkg::OFF_WINDOW: begin
            r[WIN_W-1:0] = s.window;
         end
         hem_pkg::OFF_IRQ_EN: begin
            r[1:0] = s.irq_en;
         end
         hem_pkg::OFF_IRQ_FLAG: begin
            r[1:0] = s.flags;
         end
         hem_pkg::OFF_RESULT: begin
            r[RESULT_W-1:0] = s.result;
         end
         hem_pkg::OFF_STATUS: begin
            r[hem_pkg::STAT_PH_LSB +: 2]  = s.phase;
            r[hem_pkg::STAT_FLG_LSB +: 2] = s.flags;
         end
         default: begin
            r = 32'h0;
         end
      endcase
      return r;
   endfunction : read_reg

   function automatic logic addr_known(input logic [7:0] a);
      logic k;
      case (a)
         hem_pkg::OFF_CTRL,
         hem_pkg::OFF_WINDOW,
         hem_pkg::OFF_IRQ_EN,
         hem_pkg::OFF_IRQ_FLAG,
         hem_pkg::OFF_RESULT,
         hem_pkg::OFF_STATUS: begin
            k = 1'b1;
         end
         default: begin
            k = 1'b0;
         end
      endcase
      return k;
   endfunction : addr_known

   // ****************************************
   // sub-blocks
   // ****************************************
   hem_timebase #(
      .TICK_CYC (TICK_CYC)
   ) u_timebase (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .run_i (state_ff.phase != hem_pkg::PH_IDLE),
      .tick_o(tick)
   );

   hem_accum #(
      .RESULT_W(RESULT_W),
      .ENERGY_W(ENERGY_W)
   ) u_accum (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clr_i   (acc_clr),
      .pulse_i (acc_pulse),
      .mode_i  (state_ff.mode),
      .energy_i(pulse_energy_i),
      .sum_o   (acc_sum)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      flag_set  = 2'h0;
      flag_clr  = 2'h0;
      publish   = 1'b0;
      acc_clr   = 1'b0;
      win_len   = (state_ff.window == '0) ? WIN_W'(1) : state_ff.window;
      phase_end = tick && (state_ff.win_cnt + WIN_W'(1) >= win_len);
      // only pulses inside the window count
      acc_pulse = conv_pulse_i && (state_ff.phase == hem_pkg::PH_MEASURE);

      // bus-ready event once after reset
      if (!state_ff.booted) begin
         nxt_state.booted        = 1'b1;
         flag_set[hem_pkg::IRQ_RDY_BIT] = 1'b1;
      end

      // write channel
      if (s_axi_awvalid && state_ff.awready) begin
         nxt_state.aw_have = 1'b1;
         nxt_state.waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_ff.wready) begin
         nxt_state.w_have = 1'b1;
         nxt_state.wdata  = s_axi_wdata;
         nxt_state.wstrb  = s_axi_wstrb;
      end
      if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end
      if (state_ff.aw_have && state_ff.w_have && !state_ff.bvalid) begin
         nxt_state.aw_have = 1'b0;
         nxt_state.w_have  = 1'b0;
         nxt_state.bvalid  = 1'b1;
         nxt_state.bresp   = addr_known(state_ff.waddr) ? hem_pkg::RESP_OKAY
                                                         : hem_pkg::RESP_SLVERR;
         case (state_ff.waddr)
            hem_pkg::OFF_CTRL: begin
               if (state_ff.wstrb[0]) begin
                  nxt_state.enable = state_ff.wdata[hem_pkg::CTRL_EN_BIT];
                  nxt_state.mode   = state_ff.wdata[hem_pkg::CTRL_MODE_BIT];
               end
            end
            hem_pkg::OFF_WINDOW: begin
               nxt_state.window = WIN_W'(hem_pkg::apply_strb(32'(state_ff.window),
                                                             state_ff.wdata,
                                                             state_ff.wstrb));
            end
            hem_pkg::OFF_IRQ_EN: begin
               if (state_ff.wstrb[0]) begin
                  nxt_state.irq_en = state_ff.wdata[1:0];
               end
            end
            default: begin
               nxt_state.bresp = nxt_state.bresp;
            end
         endcase
      end
      nxt_state.awready = !nxt_state.aw_have && !nxt_state.bvalid;
      nxt_state.wready  = !nxt_state.w_have && !nxt_state.bvalid;

      // read channel
      if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state_ff.arready) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = read_reg(state_ff, s_axi_araddr);
         nxt_state.rresp  = addr_known(s_axi_araddr) ? hem_pkg::RESP_OKAY
                                                     : hem_pkg::RESP_SLVERR;
         if (s_axi_araddr == hem_pkg::OFF_IRQ_FLAG) begin
            flag_clr = state_ff.flags;
         end
      end
      nxt_state.arready = !nxt_state.rvalid;

      // measurement sequencer
      case (state_ff.phase)
         hem_pkg::PH_IDLE: begin
            acc_clr = 1'b1;
            nxt_state.win_cnt = '0;
            if (state_ff.enable) begin
               nxt_state.phase = hem_pkg::PH_MEASURE;
            end
         end
         hem_pkg::PH_MEASURE: begin
            if (phase_end) begin
               nxt_state.win_cnt = '0;
               nxt_state.phase   = hem_pkg::PH_WAIT;
            end else if (tick) begin
               nxt_state.win_cnt = state_ff.win_cnt + WIN_W'(1);
            end
         end
         hem_pkg::PH_WAIT: begin
            if (phase_end) begin
               nxt_state.win_cnt = '0;
               publish           = 1'b1;
               acc_clr           = 1'b1;
               nxt_state.phase   = hem_pkg::PH_MEASURE;
            end else if (tick) begin
               nxt_state.win_cnt = state_ff.win_cnt + WIN_W'(1);
            end
         end
         default: begin
            nxt_state.phase = hem_pkg::PH_IDLE;
         end
      endcase
      if (!state_ff.enable) begin
         nxt_state.phase = hem_pkg::PH_IDLE;
      end

      if (publish) begin
         nxt_state.result                = acc_sum;
         flag_set[hem_pkg::IRQ_DONE_BIT] = 1'b1;
      end

      // set wins over read clear
      nxt_state.flags = (state_ff.flags & ~flag_clr) | flag_set;

      nxt_state.irq = |(nxt_state.flags & state_ff.irq_en);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff         <= '0;
         state_ff.window  <= WIN_W'(hem_pkg::WINDOW_RST);
         state_ff.irq_en  <= hem_pkg::IRQ_EN_RST;
         state_ff.phase   <= hem_pkg::PH_IDLE;
         state_ff.enable  <= hem_pkg::CTRL_RST[hem_pkg::CTRL_EN_BIT];
         state_ff.mode    <= hem_pkg::CTRL_RST[hem_pkg::CTRL_MODE_BIT];
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign irq_o         = state_ff.irq;
   assign s_axi_awready = state_ff.awready;
   assign s_axi_wready  = state_ff.wready;
   assign s_axi_bvalid  = state_ff.bvalid;
   assign s_axi_bresp   = state_ff.bresp;
   assign s_axi_arready = state_ff.arready;
   assign s_axi_rvalid  = state_ff.rvalid;
   assign s_axi_rdata   = state_ff.rdata;
   assign s_axi_rresp   = state_ff.rresp;

endmodule : harvest_energy_monitor

//--- pkg/hem_pkg.sv
// constants and types shared by the energy monitor files
package hem_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_WINDOW    = 8'h04;
   localparam logic [7:0]  OFF_IRQ_EN    = 8'h08;
   localparam logic [7:0]  OFF_IRQ_FLAG  = 8'h0c;
   localparam logic [7:0]  OFF_RESULT    = 8'h10;
   localparam logic [7:0]  OFF_STATUS    = 8'h14;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_MODE_BIT = 1;
   localparam int          IRQ_RDY_BIT   = 0;
   localparam int          IRQ_DONE_BIT  = 1;
   localparam int          STAT_PH_LSB   = 0;
   localparam int          STAT_FLG_LSB  = 4;
   localparam int          WIN_W         = 16;
   localparam int          ENERGY_W      = 16;
   localparam int          RESULT_W      = 32;
   localparam logic [1:0]  CTRL_RST      = 2'h0;
   localparam logic [15:0] WINDOW_RST    = 16'h000a;
   localparam logic [1:0]  IRQ_EN_RST    = 2'h1;
   localparam logic        MODE_PULSE    = 1'b0;
   localparam logic        MODE_POWER    = 1'b1;

   // ****************************************
   // bus answers
   // ****************************************
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ****************************************
   // timing
   // ****************************************
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          TICK_NS       = 1000000;
   localparam int          TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_MEASURE,
      PH_WAIT
   } phase_t;

   // byte-lane merge of a write
   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : apply_strb

endpackage : hem_pkg

//--- design/hem_timebase.sv
// divider giving a one-cycle tick enable for window timing
`timescale 1ns/1ps
module hem_timebase #(
   parameter int TICK_CYC = hem_pkg::TICK_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   output logic      tick_o
);

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } tb_state_t;

   tb_state_t state_ff;
   tb_state_t nxt_state;

   // ****************************************
   // divider
   // ****************************************
   always_comb begin
      nxt_state      = state_ff;
      nxt_state.tick = 1'b0;
      if (!run_i) begin
         nxt_state.cnt = 32'h0;
      end else if (state_ff.cnt >= 32'(TICK_CYC - 1)) begin
         nxt_state.cnt  = 32'h0;
         nxt_state.tick = 1'b1;
      end else begin
         nxt_state.cnt = state_ff.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign tick_o = state_ff.tick;

endmodule : hem_timebase

//--- design/hem_accum.sv
// saturating pulse counter and energy integrator
`timescale 1ns/1ps
module hem_accum #(
   parameter int RESULT_W = hem_pkg::RESULT_W,
   parameter int ENERGY_W = hem_pkg::ENERGY_W
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                clr_i,
   input  wire logic                pulse_i,
   input  wire logic                mode_i,
   input  wire logic [ENERGY_W-1:0] energy_i,
   output logic      [RESULT_W-1:0] sum_o
);

   typedef struct packed {
      logic [RESULT_W-1:0] sum;
   } acc_state_t;

   acc_state_t      state_ff;
   acc_state_t      nxt_state;
   logic [RESULT_W:0] wide;
   logic [RESULT_W-1:0] step;

   // ****************************************
   // accumulate
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      step = (mode_i == hem_pkg::MODE_PULSE) ? RESULT_W'(1) : RESULT_W'(energy_i);
      wide = {1'b0, state_ff.sum} + {1'b0, step};
      if (clr_i) begin
         nxt_state.sum = '0;
      end else if (pulse_i) begin
         nxt_state.sum = wide[RESULT_W] ? '1 : wide[RESULT_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign sum_o = state_ff.sum;

endmodule : hem_accum

//--- tb/harvest_energy_monitor_props.sv
// assertion checker for the energy monitor ports
`timescale 1ns/1ps
module harvest_energy_monitor_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        irq_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ****************************************
   // sequences and assertions
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence rst_left;
      rst_i ##1 !rst_i;
   endsequence

   a_reset_quiet: assert property (disable iff (1'h0) rst_i |=> !irq_o && !s_axi_awready
      && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not quiet after reset");
   a_boot_irq: assert property (disable iff (1'h0) rst_left |-> ##[1:3] (irq_o || rst_i))
      else $error("no interrupt after reset release");
   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped");
   a_unmapped_rd: assert property (rd_taken ##0 (s_axi_araddr > 8'h17) |=>
      s_axi_rresp == hem_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_refuse_wr: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_refuse_rd: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
endmodule : harvest_energy_monitor_props

bind harvest_energy_monitor harvest_energy_monitor_props i_harvest_energy_monitor_props (.*);

//--- tb/conv_pulse_src.sv
// converter pulse source feeding the monitor
`timescale 1ns/1ps
module conv_pulse_src #(
   parameter int ENERGY_W = hem_pkg::ENERGY_W
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                start_i,
   input  wire logic [7:0]          count_i,
   input  wire logic [ENERGY_W-1:0] energy_i,
   output logic                     conv_pulse_o,
   output logic      [ENERGY_W-1:0] pulse_energy_o,
   output logic                     busy_o
);
   logic [7:0]          left_ff;
   logic                gap_ff;
   logic [ENERGY_W-1:0] nrg_ff;

   // one pulse every other cycle, energy bus scrambled between pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_ff        <= 8'h0;
         gap_ff         <= 1'h0;
         nrg_ff         <= '0;
         conv_pulse_o   <= 1'h0;
         pulse_energy_o <= '0;
      end else if (start_i) begin
         left_ff        <= count_i;
         nrg_ff         <= energy_i;
         gap_ff         <= 1'h0;
         conv_pulse_o   <= 1'h0;
         pulse_energy_o <= ~pulse_energy_o;
      end else if (left_ff != 8'h0 && !gap_ff) begin
         left_ff        <= left_ff - 8'h1;
         gap_ff         <= 1'h1;
         conv_pulse_o   <= 1'h1;
         pulse_energy_o <= nrg_ff;
      end else begin
         gap_ff         <= 1'h0;
         conv_pulse_o   <= 1'h0;
         pulse_energy_o <= ~pulse_energy_o;
      end
   end
   assign busy_o = (left_ff != 8'h0) || conv_pulse_o;
endmodule : conv_pulse_src

//--- tb/harvest_energy_monitor_tb.sv
// self-checking bench for the energy monitor
`timescale 1ns/1ps
module harvest_energy_monitor_tb;
   localparam int TICK = 8;
   localparam int WIN  = 3;
   localparam int PER  = 2 * WIN * TICK;

   logic        rst_i = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, src_go = 1'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, src_cnt = 8'h0;
   logic [15:0] src_nrg = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        clk_i, conv_pulse_i, irq_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, src_busy;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] pulse_energy_i;
   logic [31:0] s_axi_rdata, rd;
   int          n_errors = 0, n_checks = 0, n_cyc = 0, t0;

   harvest_energy_monitor #(.TICK_CYC(TICK)) i_harvest_energy_monitor (.*);
   conv_pulse_src i_conv_pulse_src (.clk_i(clk_i), .rst_i(rst_i), .start_i(src_go),
      .count_i(src_cnt), .energy_i(src_nrg), .conv_pulse_o(conv_pulse_i),
      .pulse_energy_o(pulse_energy_i), .busy_o(src_busy));

   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == 3000) begin
         n_errors = n_errors + 1;
         end_sim();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_val

   task automatic chk_resp(input string nm, input logic [1:0] exp);
      n_checks++;
      if (rsp !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, rsp);
      end
   endtask : chk_resp

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'h1;
      w = 1'h1;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      while (aw || w) begin
         @(posedge clk_i);
         if (aw && s_axi_awready === 1'h1) begin
            aw = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (w && s_axi_wready === 1'h1) begin
            w = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge clk_i); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h1;
      @(posedge clk_i);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk_i); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk_i); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h1;
      @(posedge clk_i);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : axi_rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      axi_rd(a);
      chk_val($sformatf("register %h", a), exp, rd & m);
   endtask : rd_chk

   task automatic wait_rise();
      do @(posedge clk_i); while (irq_o !== 1'h0);
      do @(posedge clk_i); while (irq_o !== 1'h1);
   endtask : wait_rise

   task automatic burst(input logic [7:0] n, input logic [15:0] e);
      src_cnt <= n;
      src_nrg <= e;
      src_go  <= 1'h1;
      @(posedge clk_i);
      src_go <= 1'h0;
      do @(posedge clk_i); while (src_busy === 1'h1);
   endtask : burst

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk_val("irq after reset", 32'h1, {31'h0, irq_o});
      rd_chk(hem_pkg::OFF_IRQ_EN, 32'h3, 32'h1);
      rd_chk(hem_pkg::OFF_WINDOW, 32'hffff, 32'ha);
      rd_chk(hem_pkg::OFF_CTRL, 32'h3, 32'h0);
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h1);
      rd_chk(8'h18, 32'hffffffff, 32'h0);
      chk_resp("unmapped read", hem_pkg::RESP_SLVERR);
      axi_wr(8'h18, 32'h1);
      chk_resp("unmapped write", hem_pkg::RESP_SLVERR);
      chk_val("irq after flag read", 32'h0, {31'h0, irq_o});
      $display("test reset done");

      axi_wr(hem_pkg::OFF_WINDOW, 32'(WIN));
      axi_wr(hem_pkg::OFF_CTRL, 32'h1);
      t0 = 0;
      repeat (2 * PER + 8) begin
         @(posedge clk_i);
         if (irq_o !== 1'h0) t0++;
      end
      chk_val("irq while done masked", 32'h0, 32'(t0));
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h2);
      $display("test masked done");

      axi_wr(hem_pkg::OFF_IRQ_EN, 32'h3);
      wait_rise();
      t0 = n_cyc;
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h2);
      burst(8'h4, 16'h0);
      while (n_cyc < t0 + 30) @(posedge clk_i);
      burst(8'h3, 16'h0);
      wait_rise();
      chk_val("cycle length", 32'(PER), 32'(n_cyc - t0));
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h2);
      rd_chk(hem_pkg::OFF_RESULT, 32'hffffffff, 32'h4);
      $display("test pulse count done");

      axi_wr(hem_pkg::OFF_CTRL, 32'h3);
      wait_rise();
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h2);
      burst(8'h4, 16'h0123);
      wait_rise();
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h2);
      rd_chk(hem_pkg::OFF_RESULT, 32'hffffffff, 32'h48c);
      $display("test power meter done");

      axi_wr(hem_pkg::OFF_RESULT, 32'h0);
      chk_resp("result write", hem_pkg::RESP_OKAY);
      axi_wr(hem_pkg::OFF_CTRL, 32'h0);
      rd_chk(hem_pkg::OFF_STATUS, 32'h3, 32'h0);
      rd_chk(hem_pkg::OFF_RESULT, 32'hffffffff, 32'h48c);
      $display("test disable done");

      s_axi_wstrb <= 4'h1;
      axi_wr(hem_pkg::OFF_WINDOW, 32'h0507);
      s_axi_wstrb <= 4'hf;
      rd_chk(hem_pkg::OFF_WINDOW, 32'hffff, 32'h7);
      $display("test byte strobe done");

      rst_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk_val("irq after second reset", 32'h1, {31'h0, irq_o});
      rd_chk(hem_pkg::OFF_IRQ_EN, 32'h3, 32'h1);
      rd_chk(hem_pkg::OFF_WINDOW, 32'hffff, 32'ha);
      rd_chk(hem_pkg::OFF_IRQ_FLAG, 32'h3, 32'h1);
      $display("test second reset done");
      end_sim();
   end
endmodule : harvest_energy_monitor_tb
